// file: src/bsvc_consts.svh
// offsets, field positions, reset values and figures of the strap capture block
`ifndef BSVC_CONSTS_SVH
`define BSVC_CONSTS_SVH

`define BSVC_ADDR_W        8
`define BSVC_OFF_STATUS    8'h00
`define BSVC_OFF_PCLK      8'h04
`define BSVC_OFF_SMBCTL    8'h08
`define BSVC_OFF_HALTCTL   8'h0C
`define BSVC_OFF_STATE     8'h10

`define BSVC_VEC_W         25
`define BSVC_F_REF         0
`define BSVC_F_CLK_LO      1
`define BSVC_F_CLK_HI      2
`define BSVC_F_EE_LO       3
`define BSVC_F_EE_HI       6
`define BSVC_F_SLOW        7
`define BSVC_F_MRG_LO      8
`define BSVC_F_MRG_HI      15
`define BSVC_F_HALT        16
`define BSVC_F_SA_LO       17
`define BSVC_F_SA_HI       20
`define BSVC_F_MD_LO       21
`define BSVC_F_MD_HI       24

`define BSVC_REF_LOW_MHZ   8'h64
`define BSVC_REF_HIGH_MHZ  8'h7D
`define BSVC_PRESC_FAST    8'h3F
`define BSVC_PRESC_SLOW    8'hFF
`define BSVC_RST_STATUS    25'h0000000
`define BSVC_RST_PCLK      2'h0
`define BSVC_RST_PRESC     8'h00

`define BSVC_RESP_OKAY     2'h0
`define BSVC_RESP_SLVERR   2'h2

`endif

// file: src/bsvc_pkg.sv
// types of the strap capture block
package bsvc_pkg;

    typedef enum logic [2:0] {
        BSVC_FILL0 = 3'h0,
        BSVC_FILL1 = 3'h1,
        BSVC_TAKE  = 3'h3,
        BSVC_HALT  = 3'h2,
        BSVC_RUN   = 3'h6
    } bsvc_state_t;

endpackage

// file: src/bsvc_sync.sv
// two-flop synchroniser for the strap pins
`timescale 1ns/1ns
module bsvc_sync #(
    parameter int WIDTH = 25
) (
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_meta[i]  = async_i[i];
                next_stage[i] = meta[i];
            end
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta[i]  <= 1'b0;
                    stage[i] <= 1'b0;
                end else begin
                    meta[i]  <= next_meta[i];
                    stage[i] <= next_stage[i];
                end
            end
        end
    endgenerate

    assign sync_o = stage;
endmodule // bsvc_sync

// file: src/bsvc_top.sv
// strap vector capture with its register slave on axi4-lite
// Operation
// - every strap is captured as part of the fundamental reset sequence.
// - capture happens on the third clock edge after the global reset input is released.
// - strap changes after capture have no effect on the block.
// - the captured straps are readable in the strap capture status register.
// - further setup comes from an smbus master or the serial eeprom.
// - a fixed strap sets the assumed reference clock frequency.
// - the frequency strap selects 100 MHz or 125 MHz.
// - clocking strap seeds the port clocking register, software may overwrite.
// - bit 0 sets port 0 common clock, bit 1 all other ports.
// - four fixed straps give the upper eeprom smbus address bits.
// - slow strap seeds the smbus prescaler, software may overwrite it.
// - eight fixed merge straps merge each even/odd port pair.
// - captured hold strap keeps the device in reset with smbus active.
// - clearing the halt bit in switch control releases the device.
// - four fixed straps give the slave smbus address bits 5,3:1.
// - a four-bit fixed strap selects the switch operating mode.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "bsvc_consts.svh"
`timescale 1ns/1ns
module bsvc_top (
    input  wire logic                     core_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     ref_freq_select_strap_i,
    input  wire logic [1:0]               port_clocking_strap_i,
    input  wire logic [3:0]               eeprom_addr_strap_i,
    input  wire logic                     master_smbus_slow_strap_i,
    input  wire logic [7:0]               pair_merge_strap_i,
    input  wire logic                     reset_hold_strap_i,
    input  wire logic [3:0]               slave_smbus_addr_strap_i,
    input  wire logic [3:0]               switch_operating_strap_i,
    input  wire logic [`BSVC_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`BSVC_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic [7:0]                    ref_freq_mhz_o,
    output logic                          port0_common_clk_o,
    output logic                          other_ports_common_clk_o,
    output logic [3:0]                    eeprom_addr_hi_o,
    output logic [7:0]                    smbus_prescale_o,
    output logic [7:0]                    pair_merged_o,
    output logic [3:0]                    slave_addr_bits_o,
    output logic [3:0]                    switch_mode_o,
    output logic                          device_hold_o,
    output logic                          smbus_if_en_o,
    output logic                          eeprom_load_start_o,
    output bsvc_pkg::bsvc_state_t         state_o
);
    import bsvc_pkg::*;

    localparam int VW = `BSVC_VEC_W;

    function automatic logic addr_known(input logic [`BSVC_ADDR_W-1:0] a);
        addr_known = (a == `BSVC_OFF_STATUS) || (a == `BSVC_OFF_PCLK) ||
                     (a == `BSVC_OFF_SMBCTL) || (a == `BSVC_OFF_HALTCTL) ||
                     (a == `BSVC_OFF_STATE);
    endfunction

    logic [VW-1:0] strap_raw;
    logic [VW-1:0] strap_sync;

    assign strap_raw = {switch_operating_strap_i, slave_smbus_addr_strap_i,
                        reset_hold_strap_i, pair_merge_strap_i,
                        master_smbus_slow_strap_i, eeprom_addr_strap_i,
                        port_clocking_strap_i, ref_freq_select_strap_i};

    bsvc_sync #(.WIDTH(VW)) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (strap_raw),
        .sync_o     (strap_sync)
    );

    // control and captured state
    bsvc_state_t   state;
    bsvc_state_t   next_state;
    logic [VW-1:0] status;
    logic [VW-1:0] next_status;
    logic [1:0]    pclk;
    logic [1:0]    next_pclk;
    logic [7:0]    presc;
    logic [7:0]    next_presc;
    logic          halt;
    logic          next_halt;
    logic          load;
    logic          next_load;

    // bus slave state
    logic                    aw_held;
    logic                    next_aw_held;
    logic [`BSVC_ADDR_W-1:0] aw_addr;
    logic [`BSVC_ADDR_W-1:0] next_aw_addr;
    logic                    w_held;
    logic                    next_w_held;
    logic [31:0]             w_data;
    logic [31:0]             next_w_data;
    logic [3:0]              w_strb;
    logic [3:0]              next_w_strb;
    logic                    bvalid;
    logic                    next_bvalid;
    logic [1:0]              bresp;
    logic [1:0]              next_bresp;
    logic                    rvalid;
    logic                    next_rvalid;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic [1:0]              rresp;
    logic [1:0]              next_rresp;
    logic                    wr_commit;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !rvalid;
    assign wr_commit     = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_commit) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_known(aw_addr) ? `BSVC_RESP_OKAY : `BSVC_RESP_SLVERR;
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = addr_known(s_axi_araddr) ? `BSVC_RESP_OKAY : `BSVC_RESP_SLVERR;
            case (s_axi_araddr)
                `BSVC_OFF_STATUS: next_rdata = {7'h00, status};
                `BSVC_OFF_PCLK:   next_rdata = {30'h0, pclk};
                `BSVC_OFF_SMBCTL: next_rdata = {24'h0, presc};
                `BSVC_OFF_HALTCTL: next_rdata = {31'h0, halt};
                `BSVC_OFF_STATE:  next_rdata = {29'h0, state};
                default:          next_rdata = 32'h0;
            endcase
        end
    end

    always_comb begin
        next_state  = state;
        next_status = status;
        next_pclk   = pclk;
        next_presc  = presc;
        next_halt   = halt;
        next_load   = 1'b0;
        // software overrides the writable copies only; the status copy has no write path
        if (wr_commit && w_strb[0]) begin
            case (aw_addr)
                `BSVC_OFF_PCLK:   next_pclk  = w_data[1:0];
                `BSVC_OFF_SMBCTL: next_presc = w_data[7:0];
                `BSVC_OFF_HALTCTL: next_halt = halt & w_data[0];
                default:          next_halt  = halt;
            endcase
        end
        case (state)
            BSVC_FILL0: begin
                next_state = BSVC_FILL1;
            end
            BSVC_FILL1: begin
                next_state = BSVC_TAKE;
            end
            BSVC_TAKE: begin
                // capture wins over any write landing in the same cycle
                next_status = strap_sync;
                next_pclk   = strap_sync[`BSVC_F_CLK_HI:`BSVC_F_CLK_LO];
                next_presc  = strap_sync[`BSVC_F_SLOW] ? `BSVC_PRESC_SLOW
                                                       : `BSVC_PRESC_FAST;
                next_halt   = strap_sync[`BSVC_F_HALT];
                next_load   = 1'b1;
                next_state  = strap_sync[`BSVC_F_HALT] ? BSVC_HALT : BSVC_RUN;
            end
            BSVC_HALT: begin
                if (!halt) begin
                    next_state = BSVC_RUN;
                end
            end
            BSVC_RUN: begin
                next_state = BSVC_RUN;
            end
            default: begin
                next_state = BSVC_FILL0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state  <= BSVC_FILL0;
            status <= `BSVC_RST_STATUS;
            pclk   <= `BSVC_RST_PCLK;
            presc  <= `BSVC_RST_PRESC;
            halt   <= 1'b0;
            load   <= 1'b0;
        end else begin
            state  <= next_state;
            status <= next_status;
            pclk   <= next_pclk;
            presc  <= next_presc;
            halt   <= next_halt;
            load   <= next_load;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `BSVC_RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `BSVC_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held  <= next_w_held;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = rresp;

    // fixed settings come straight from the captured copy
    assign ref_freq_mhz_o = status[`BSVC_F_REF] ? `BSVC_REF_HIGH_MHZ
                                                : `BSVC_REF_LOW_MHZ;
    assign port0_common_clk_o       = pclk[0];
    assign other_ports_common_clk_o = pclk[1];
    assign eeprom_addr_hi_o  = status[`BSVC_F_EE_HI:`BSVC_F_EE_LO];
    assign smbus_prescale_o  = presc;
    assign pair_merged_o     = status[`BSVC_F_MRG_HI:`BSVC_F_MRG_LO];
    assign slave_addr_bits_o = status[`BSVC_F_SA_HI:`BSVC_F_SA_LO];
    assign switch_mode_o     = status[`BSVC_F_MD_HI:`BSVC_F_MD_LO];
    assign device_hold_o     = (state != BSVC_RUN);
    assign smbus_if_en_o     = (state == BSVC_HALT) || (state == BSVC_RUN);
    assign eeprom_load_start_o = load;
    assign state_o           = state;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence seq_fill;
        (state == BSVC_FILL0) ##1 (state == BSVC_FILL1) ##1 (state == BSVC_TAKE);
    endsequence
    sequence seq_settled;
        (state == BSVC_HALT) || (state == BSVC_RUN);
    endsequence

    chk_boot_order: assert property ((state == BSVC_FILL0) |-> seq_fill ##1 seq_settled)
        else $error("boot capture sequence out of order");
    chk_capture_value: assert property ((state == BSVC_TAKE) |=> status == $past(strap_sync))
        else $error("status does not hold the captured straps");
    chk_status_frozen: assert property (seq_settled |=> $stable(status))
        else $error("status changed after capture");
    chk_halt_entry: assert property ((state == BSVC_TAKE) && strap_sync[`BSVC_F_HALT] |=> (state == BSVC_HALT) && halt && device_hold_o && smbus_if_en_o)
        else $error("hold strap did not halt the device");
    chk_halt_release: assert property ((state == BSVC_HALT) && wr_commit && w_strb[0] && (aw_addr == `BSVC_OFF_HALTCTL) && !w_data[0] |-> ##[1:2] (state == BSVC_RUN) && !device_hold_o)
        else $error("clearing halt did not release the device");
    chk_pclk_seed: assert property ((state == BSVC_TAKE) |=> pclk == status[`BSVC_F_CLK_HI:`BSVC_F_CLK_LO] && port0_common_clk_o == pclk[0])
        else $error("clocking copy not seeded from strap");
    chk_presc_seed: assert property ((state == BSVC_TAKE) |=> presc == (status[`BSVC_F_SLOW] ? `BSVC_PRESC_SLOW : `BSVC_PRESC_FAST))
        else $error("prescaler not seeded from slow strap");
    chk_ref_freq: assert property (seq_settled |-> ref_freq_mhz_o == (status[0] ? 8'h7D : 8'h64))
        else $error("reference frequency mismatch");
    chk_load_once: assert property ((state == BSVC_TAKE) |=> eeprom_load_start_o ##1 !eeprom_load_start_o)
        else $error("eeprom load pulse malformed");
    chk_write_resp: assert property (wr_commit |=> bvalid && (bresp == (addr_known($past(aw_addr)) ? 2'h0 : 2'h2)))
        else $error("write response missing or wrong");
endmodule // bsvc_top

// file: test/bsvc_strap_board.sv
// board model that drives the strap pins of the capture block
`timescale 1ns/1ns
module bsvc_strap_board (
    input  wire logic        core_clk_i,
    input  wire logic [24:0] vec_i,
    input  wire logic        scramble_i,
    output logic             ref_freq_select_strap_o,
    output logic [1:0]       port_clocking_strap_o,
    output logic [3:0]       eeprom_addr_strap_o,
    output logic             master_smbus_slow_strap_o,
    output logic [7:0]       pair_merge_strap_o,
    output logic             reset_hold_strap_o,
    output logic [3:0]       slave_smbus_addr_strap_o,
    output logic [3:0]       switch_operating_strap_o
);
    logic [24:0] pins;

    // straps sit still through reset; once scrambled they change every cycle,
    // which a capture after reset must not follow
    always_ff @(posedge core_clk_i) begin
        if (scramble_i) begin
            pins <= ~{pins[23:0], pins[24]};
        end else begin
            pins <= vec_i;
        end
    end

    assign ref_freq_select_strap_o   = pins[0];
    assign port_clocking_strap_o     = pins[2:1];
    assign eeprom_addr_strap_o       = pins[6:3];
    assign master_smbus_slow_strap_o = pins[7];
    assign pair_merge_strap_o        = pins[15:8];
    assign reset_hold_strap_o        = pins[16];
    assign slave_smbus_addr_strap_o  = pins[20:17];
    assign switch_operating_strap_o  = pins[24:21];
endmodule // bsvc_strap_board

// file: test/tb_top.sv
// self-checking bench of the strap capture block
`include "bsvc_consts.svh"
`timescale 1ns/1ns
module tb_top;
    import bsvc_pkg::*;
    logic        core_clk_i, nrst_i, scramble;
    logic [24:0] vec, v;
    logic        ref_freq_select_strap_i, master_smbus_slow_strap_i, reset_hold_strap_i;
    logic [1:0]  port_clocking_strap_i, s_axi_bresp, s_axi_rresp;
    logic [3:0]  eeprom_addr_strap_i, slave_smbus_addr_strap_i, switch_operating_strap_i;
    logic [7:0]  pair_merge_strap_i, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, eeprom_addr_hi_o, slave_addr_bits_o, switch_mode_o;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  ref_freq_mhz_o, smbus_prescale_o, pair_merged_o;
    logic        port0_common_clk_o, other_ports_common_clk_o, device_hold_o;
    logic        smbus_if_en_o, eeprom_load_start_o;
    bsvc_state_t state_o;
    logic [33:0] rd_q[$];
    logic [33:0] e;
    logic [1:0]  wr_q[$];
    int          error_cnt, n_tests;

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    bsvc_strap_board bsvc_strap_board_i (
        .core_clk_i, .vec_i(vec), .scramble_i(scramble),
        .ref_freq_select_strap_o(ref_freq_select_strap_i),
        .port_clocking_strap_o(port_clocking_strap_i),
        .eeprom_addr_strap_o(eeprom_addr_strap_i),
        .master_smbus_slow_strap_o(master_smbus_slow_strap_i),
        .pair_merge_strap_o(pair_merge_strap_i),
        .reset_hold_strap_o(reset_hold_strap_i),
        .slave_smbus_addr_strap_o(slave_smbus_addr_strap_i),
        .switch_operating_strap_o(switch_operating_strap_i));

    bsvc_top bsvc_top_i (
        .core_clk_i, .nrst_i, .ref_freq_select_strap_i, .port_clocking_strap_i,
        .eeprom_addr_strap_i, .master_smbus_slow_strap_i, .pair_merge_strap_i,
        .reset_hold_strap_i, .slave_smbus_addr_strap_i, .switch_operating_strap_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ref_freq_mhz_o, .port0_common_clk_o,
        .other_ports_common_clk_o, .eeprom_addr_hi_o, .smbus_prescale_o, .pair_merged_o,
        .slave_addr_bits_o, .switch_mode_o, .device_hold_o, .smbus_if_en_o,
        .eeprom_load_start_o, .state_o);

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic bad(input string m);
        error_cnt++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad(m);
        end
    endtask

    task automatic tick(inout int n);
        @(posedge core_clk_i);
        n++;
        if (n > 20) begin
            bad("wait timed out");
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s,
                      input logic [1:0] er);
        int  n;
        logic aw_d, w_d;
        n = 0;
        aw_d = 1'b0;
        w_d = 1'b0;
        wr_q.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= dw;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            tick(n);
            if (!aw_d && s_axi_awready) begin
                aw_d = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready) begin
                w_d = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do tick(n); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        rd_q.push_back({er, ed});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do tick(n); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // halt is accepted as a stopping point only when run is not demanded
    task automatic wait_for(input logic want_run);
        int n;
        n = 0;
        while (state_o !== BSVC_RUN && (want_run || state_o !== BSVC_HALT)) begin
            tick(n);
        end
    endtask

    task automatic check_caps(input logic [24:0] c);
        cmp(ref_freq_mhz_o, c[0] ? `BSVC_REF_HIGH_MHZ : `BSVC_REF_LOW_MHZ, "ref");
        cmp(eeprom_addr_hi_o, c[6:3], "eeprom addr");
        cmp(pair_merged_o, c[15:8], "merge");
        cmp(slave_addr_bits_o, c[20:17], "slave addr");
        cmp(switch_mode_o, c[24:21], "mode");
        cmp(smbus_if_en_o, 1'b1, "smbus enable");
        rd(`BSVC_OFF_STATUS, {7'h00, c}, `BSVC_RESP_OKAY);
    endtask

    always @(posedge core_clk_i) begin
        if (nrst_i && s_axi_bvalid && s_axi_bready) begin
            if (wr_q.size() == 0) bad("unexpected write response");
            else cmp(s_axi_bresp, wr_q.pop_front(), "bresp");
        end
        if (nrst_i && s_axi_rvalid && s_axi_rready) begin
            if (rd_q.size() == 0) bad("unexpected read data");
            else begin
                e = rd_q.pop_front();
                cmp(s_axi_rdata, e[31:0], "rdata");
                cmp(s_axi_rresp, e[33:32], "rresp");
            end
        end
    end

    initial begin
        {nrst_i, scramble, vec, v, d, error_cnt, n_tests} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        void'($urandom(32'hE7B8));
        for (int i = 0; i < 4; i++) begin
            v = 25'($urandom());
            v[0] = i[0];
            v[16] = (i < 2);
            @(posedge core_clk_i);
            nrst_i <= 1'b0;
            vec <= v;
            scramble <= 1'b0;
            repeat (4) @(posedge core_clk_i);
            nrst_i <= 1'b1;
            wait_for(1'b0);
            // the start pulse launched with the capture still stands at this edge
            cmp(eeprom_load_start_o, 1'b1, "load start");
            cmp(state_o, v[16] ? BSVC_HALT : BSVC_RUN, "state");
            check_caps(v);
            cmp(device_hold_o, v[16], "hold");
            cmp(smbus_prescale_o, v[7] ? `BSVC_PRESC_SLOW : `BSVC_PRESC_FAST, "presc");
            cmp({other_ports_common_clk_o, port0_common_clk_o}, v[2:1], "clk mode");
            rd(`BSVC_OFF_PCLK, {30'h0, v[2:1]}, `BSVC_RESP_OKAY);
            rd(`BSVC_OFF_HALTCTL, {31'h0, v[16]}, `BSVC_RESP_OKAY);
            scramble <= 1'b1;
            repeat (8) @(posedge core_clk_i);
            cmp(eeprom_load_start_o, 1'b0, "load once");
            check_caps(v);
            for (int k = 0; k < 4; k++) begin
                wr(`BSVC_OFF_PCLK, 32'(k), 4'hF, `BSVC_RESP_OKAY);
                cmp({other_ports_common_clk_o, port0_common_clk_o}, k[1:0], "pclk");
            end
            // lane 0 strobe off: the write must be dropped
            wr(`BSVC_OFF_PCLK, 32'h0, 4'hE, `BSVC_RESP_OKAY);
            rd(`BSVC_OFF_PCLK, 32'h3, `BSVC_RESP_OKAY);
            d = $urandom();
            wr(`BSVC_OFF_SMBCTL, d, 4'hF, `BSVC_RESP_OKAY);
            rd(`BSVC_OFF_SMBCTL, {24'h0, d[7:0]}, `BSVC_RESP_OKAY);
            cmp(smbus_prescale_o, d[7:0], "presc write");
            wr(`BSVC_OFF_STATUS, ~d, 4'hF, `BSVC_RESP_OKAY);
            rd(`BSVC_OFF_STATUS, {7'h00, v}, `BSVC_RESP_OKAY);
            wr(8'h14, d, 4'hF, `BSVC_RESP_SLVERR);
            rd(8'h14, 32'h0, `BSVC_RESP_SLVERR);
            if (v[16]) begin
                rd(`BSVC_OFF_STATE, {29'h0, BSVC_HALT}, `BSVC_RESP_OKAY);
                wr(`BSVC_OFF_HALTCTL, 32'h1, 4'hF, `BSVC_RESP_OKAY);
                rd(`BSVC_OFF_HALTCTL, 32'h1, `BSVC_RESP_OKAY);
                wr(`BSVC_OFF_HALTCTL, 32'h0, 4'hF, `BSVC_RESP_OKAY);
                wait_for(1'b1);
            end
            cmp(device_hold_o, 1'b0, "released");
            rd(`BSVC_OFF_STATE, {29'h0, BSVC_RUN}, `BSVC_RESP_OKAY);
            $display("test boot %0d done", i);
        end
        repeat (4) @(posedge core_clk_i);
        stop_test();
    end
endmodule // tb_top
